// ==== common/umpt_pkg.sv ====
// Purpose: Shared constants for the manufacturing pin test block
// Assumes: APB byte addresses, 32-bit data, one word per register
// Notes: Request codes mirror the USB vendor control requests
package umpt_pkg;
  // APB register byte offsets
  localparam logic [7:0] OFS_SETUP_LO = 8'h00;
  localparam logic [7:0] OFS_SETUP_HI = 8'h04;
  localparam logic [7:0] OFS_DATA_LO = 8'h08;
  localparam logic [7:0] OFS_DATA_HI = 8'h0C;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_SNAP_LO = 8'h18;
  localparam logic [7:0] OFS_SNAP_HI = 8'h1C;
  // Field positions
  localparam int CTRL_EXEC_BIT = 0;
  localparam int ST_TEST_BIT = 0;
  localparam int ST_STALL_BIT = 1;
  localparam int ST_DONE_BIT = 2;
  // Vendor request encodings
  localparam logic [7:0] REQ_TYPE_OUT = 8'h40;
  localparam logic [7:0] REQ_TYPE_IN = 8'hC0;
  localparam logic [7:0] REQ_LOAD = 8'h05;
  localparam logic [7:0] REQ_READ = 8'h06;
  localparam logic [15:0] VAL_NORMAL = 16'h0000;
  localparam logic [15:0] VAL_TEST = 16'h0001;
  localparam logic [15:0] IDX_ZERO = 16'h0000;
  localparam logic [15:0] LEN_LOAD = 16'h0007;
  localparam logic [15:0] LEN_READ_MIN = 16'h0001;
  localparam logic [15:0] LEN_READ_MAX = 16'h0008;
  // Reset values and synchroniser width
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [55:0] TEST_DATA_RST = 56'h00_0000_0000_0000;
  localparam logic [63:0] SNAP_RST = 64'h0000_0000_0000_0000;
  localparam logic TEST_MODE_RST = 1'b0;
  localparam logic PIN_N_RST = 1'b1;
  localparam logic PIN_RST = 1'b0;
  localparam int SYNC_W = 28;
endpackage : umpt_pkg

// ==== rtl/umpt_pin_test.sv ====
// Purpose: Manufacturing interconnect test override and pin snapshot
// Assumes: Setup packet and data staged by software over APB, one clock
// Notes: USB transceiver pins are not routed through this block at all
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Test mode drives non-USB outputs from test data
// RULE2: Test mode blocks functional control of pins
// RULE3: Load request is type 40, code 05
// RULE4: Value zero restores normal mode; reset default
// RULE5: Value one enters test mode
// RULE6: Host sends length zero only when disabling
// RULE7: Enable needs seven bytes; longer stalls
// RULE8: Each pin follows its own test bit
// RULE9: Byte 0 maps power, reset, strobes, pull-up
// RULE10: Byte 1 maps selects, address, clock, enable
// RULE11: Bytes 2-4 map data bus and GPIO
// RULE12: Reserved test bits affect nothing
// RULE13: Data and GPIO pins can float
// RULE14: Read request is type C0, code 06, zeros
// RULE15: Read length one to eight, else stall
// RULE16: Snapshot taken at one instant, bit packed
// RULE17: Sampling works in either mode
// RULE18: Snapshot alters neither mode nor test data
// RULE19: Readback bytes 0 and 1 mapping
// RULE20: Host ignores reserved readback bits
// RULE21: Readback bytes 2 to 4 mapping
// RULE22: Readback bytes 5 and 6 mapping
// RULE23: GPIO enable zero floats the pin
// RULE24: Mode changes leave USB pins alone
module umpt_pin_test (
  input wire logic pclk, // APB clock, 200 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic func_low_power_indicator, // Functional drive
  input wire logic func_full_current_request_n, // Functional drive
  input wire logic func_drive_reset_n, // Functional drive
  input wire logic func_diow_n, // Functional drive
  input wire logic func_dior_n, // Functional drive
  input wire logic func_dmack_n, // Functional drive
  input wire logic func_disk_pullup_enable, // Functional drive
  input wire logic [1:0] func_cs_n, // Functional drive
  input wire logic [2:0] func_da, // Functional drive
  input wire logic func_scl, // Functional drive
  input wire logic [15:0] func_dd_out, // Functional data bus value
  input wire logic func_dd_oe_n, // Functional data bus enable
  input wire logic [2:0] func_gpio_out, // Functional GPIO value
  input wire logic [2:0] func_gpio_oe_n, // Functional GPIO enables
  output logic low_power_indicator, // Pin
  output logic full_current_request_n, // Pin
  output logic drive_reset_n, // Pin
  output logic diow_n, // Pin
  output logic dior_n, // Pin
  output logic dmack_n, // Pin
  output logic disk_pullup_enable, // Pin
  output logic [1:0] cs_n, // Pin
  output logic [2:0] da, // Pin
  output logic scl_out, // Pin
  output logic [15:0] dd_out, // Data bus output value
  output logic dd_oe_n, // Data bus enable, low drives
  input wire logic [15:0] dd_in, // Data bus pad level
  output logic [2:0] gpio_out, // GPIO output value
  output logic [2:0] gpio_oe_n, // GPIO enables, low drives
  input wire logic [2:0] gpio_in, // GPIO pad level
  input wire logic drive_power_valid, // Pin input
  input wire logic bus_power_valid, // Pin input
  input wire logic bus_powered_flag, // Pin input
  input wire logic disk_ready_input, // Pin input
  input wire logic system_interrupt_input, // Pin input
  input wire logic iordy, // Pin input
  input wire logic dmarq, // Pin input
  input wire logic eject_request_n, // Pin input
  input wire logic disk_interrupt_input, // Pin input
  output logic test_mode // Test mode active
);
  logic [31:0] setup_lo_reg;
  logic [31:0] setup_hi_reg;
  logic [31:0] data_lo_reg;
  logic [31:0] data_hi_reg;
  logic [55:0] test_data_reg;
  logic test_mode_reg;
  logic stall_reg;
  logic done_reg;
  logic [63:0] snap_reg;
  logic [umpt_pkg::SYNC_W-1:0] sync1_reg;
  logic [umpt_pkg::SYNC_W-1:0] sync2_reg;
  logic apb_wr;
  logic exec;
  logic addr_ok;
  logic [7:0] req_type;
  logic [7:0] req_code;
  logic [15:0] req_value;
  logic [15:0] req_index;
  logic [15:0] req_length;
  logic is_load;
  logic is_read;
  logic load_ok;
  logic read_ok;
  logic stall_set;
  logic [63:0] snap_now;
  logic [7:0] tb0;
  logic [7:0] tb1;
  logic [7:0] tb4;
  // Keep byte k of a snapshot only when k is below the requested length
  function automatic logic [63:0] mask_len(input logic [63:0] d, input logic [15:0] len);
    logic [63:0] m;
    m = '0;
    for (int k = 0; k < 8; k++)
    begin
      if (16'(k) < len)
      begin
        m[k*8 +: 8] = 8'hFF;
      end
    end
    return d & m;
  endfunction
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign exec = apb_wr && (paddr == umpt_pkg::OFS_CTRL) && pwdata[umpt_pkg::CTRL_EXEC_BIT];
  assign req_type = setup_lo_reg[7:0];
  assign req_code = setup_lo_reg[15:8];
  assign req_value = setup_lo_reg[31:16];
  assign req_index = setup_hi_reg[15:0];
  assign req_length = setup_hi_reg[31:16];
  assign tb0 = test_data_reg[7:0];
  assign tb1 = test_data_reg[15:8];
  assign tb4 = test_data_reg[39:32];
  assign test_mode = test_mode_reg;
  // RULE3 load request decode
  assign is_load = (req_type == umpt_pkg::REQ_TYPE_OUT) && (req_code == umpt_pkg::REQ_LOAD);
  // RULE14 read request decode
  assign is_read = (req_type == umpt_pkg::REQ_TYPE_IN) && (req_code == umpt_pkg::REQ_READ)
    && (req_value == umpt_pkg::VAL_NORMAL) && (req_index == umpt_pkg::IDX_ZERO);
  // RULE7 exact seven bytes
  assign load_ok = (req_value == umpt_pkg::VAL_NORMAL)
    || ((req_value == umpt_pkg::VAL_TEST) && (req_length == umpt_pkg::LEN_LOAD));
  // RULE15 length one to eight
  assign read_ok = (req_length >= umpt_pkg::LEN_READ_MIN) && (req_length <= umpt_pkg::LEN_READ_MAX);
  assign stall_set = exec && !((is_load && load_ok) || (is_read && read_ok));

  always_comb
  begin
    unique case (paddr)
      umpt_pkg::OFS_SETUP_LO, umpt_pkg::OFS_SETUP_HI, umpt_pkg::OFS_DATA_LO, umpt_pkg::OFS_DATA_HI,
      umpt_pkg::OFS_CTRL, umpt_pkg::OFS_STATUS, umpt_pkg::OFS_SNAP_LO, umpt_pkg::OFS_SNAP_HI:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addr_ok;

  always_comb
  begin
    case (paddr)
      umpt_pkg::OFS_SETUP_LO: prdata = setup_lo_reg;
      umpt_pkg::OFS_SETUP_HI: prdata = setup_hi_reg;
      umpt_pkg::OFS_DATA_LO: prdata = data_lo_reg;
      umpt_pkg::OFS_DATA_HI: prdata = data_hi_reg;
      umpt_pkg::OFS_STATUS: prdata = {29'h0000_0000, done_reg, stall_reg, test_mode_reg};
      umpt_pkg::OFS_SNAP_LO: prdata = snap_reg[31:0];
      umpt_pkg::OFS_SNAP_HI: prdata = snap_reg[63:32];
      default: prdata = 32'h0000_0000;
    endcase
  end
  // Staging registers for the setup packet and test data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      setup_lo_reg <= umpt_pkg::REG_RST;
      setup_hi_reg <= umpt_pkg::REG_RST;
      data_lo_reg <= umpt_pkg::REG_RST;
      data_hi_reg <= umpt_pkg::REG_RST;
    end
    else if (apb_wr)
    begin
      if (paddr == umpt_pkg::OFS_SETUP_LO)
        setup_lo_reg <= pwdata;
      if (paddr == umpt_pkg::OFS_SETUP_HI)
        setup_hi_reg <= pwdata;
      if (paddr == umpt_pkg::OFS_DATA_LO)
        data_lo_reg <= pwdata;
      if (paddr == umpt_pkg::OFS_DATA_HI)
        data_hi_reg <= pwdata;
    end
  end
  // Mode and latched test pattern; a read request never reaches here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // RULE4 normal after reset
      test_mode_reg <= umpt_pkg::TEST_MODE_RST;
      test_data_reg <= umpt_pkg::TEST_DATA_RST;
    end
    else if (exec && is_load)
    begin
      // RULE4 disable regardless of data
      if (req_value == umpt_pkg::VAL_NORMAL)
        test_mode_reg <= 1'b0;
      // RULE5 enter test mode
      else if (load_ok)
      begin
        test_mode_reg <= 1'b1;
        test_data_reg <= {data_hi_reg[23:0], data_lo_reg};
      end
    end
  end
  // Sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stall_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      // RULE7 oversize load stalls
      stall_reg <= stall_set || (stall_reg && !(apb_wr && (paddr == umpt_pkg::OFS_STATUS)
        && pwdata[umpt_pkg::ST_STALL_BIT]));
      done_reg <= exec || (done_reg && !(apb_wr && (paddr == umpt_pkg::OFS_STATUS)
        && pwdata[umpt_pkg::ST_DONE_BIT]));
    end
  end
  // Two-flop synchronisers for every pad input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {gpio_in, dd_in, disk_interrupt_input, eject_request_n, dmarq, iordy,
        system_interrupt_input, disk_ready_input, bus_powered_flag, bus_power_valid, drive_power_valid};
      sync2_reg <= sync1_reg;
    end
  end
  // RULE16 one-instant packing
  // RULE19 bytes 0 and 1
  // RULE21 bytes 2 to 4
  // RULE22 bytes 5 and 6
  // RULE20 reserved bits read zero
  assign snap_now = {
    8'h00,
    7'h7F, test_mode_reg,
    ~gpio_oe_n, ~dd_oe_n, 1'b0, sync2_reg[27:25],
    sync2_reg[24:17],
    sync2_reg[16:9],
    da, cs_n, 1'b0, disk_pullup_enable, dmack_n,
    dior_n, diow_n, drive_reset_n, full_current_request_n, 1'b0, low_power_indicator, 1'b1,
    sync2_reg[8],
    sync2_reg[7:0]};
  // RULE17 sample in any mode
  // RULE18 read touches only the snapshot and the status flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      snap_reg <= umpt_pkg::SNAP_RST;
    else if (exec && is_read && read_ok)
      snap_reg <= mask_len(snap_now, req_length);
  end
  // Registered pin mux; USB pins never pass here, so mode changes leave the link alone
  // RULE24 USB side untouched
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_power_indicator <= umpt_pkg::PIN_RST;
      full_current_request_n <= umpt_pkg::PIN_N_RST;
      drive_reset_n <= umpt_pkg::PIN_N_RST;
      diow_n <= umpt_pkg::PIN_N_RST;
      dior_n <= umpt_pkg::PIN_N_RST;
      dmack_n <= umpt_pkg::PIN_N_RST;
      disk_pullup_enable <= umpt_pkg::PIN_RST;
      cs_n <= {2{umpt_pkg::PIN_N_RST}};
      da <= {3{umpt_pkg::PIN_RST}};
      scl_out <= umpt_pkg::PIN_N_RST;
      dd_out <= {16{umpt_pkg::PIN_RST}};
      dd_oe_n <= umpt_pkg::PIN_N_RST;
      gpio_out <= {3{umpt_pkg::PIN_RST}};
      gpio_oe_n <= {3{umpt_pkg::PIN_N_RST}};
    end
    // RULE1 test data drives pins
    // RULE2 functional control blocked
    else if (test_mode_reg)
    begin
      // RULE8 one bit per pin
      // RULE9 byte 0 mapping
      low_power_indicator <= tb0[0];
      full_current_request_n <= tb0[2];
      drive_reset_n <= tb0[3];
      diow_n <= tb0[4];
      dior_n <= tb0[5];
      dmack_n <= tb0[6];
      disk_pullup_enable <= tb0[7];
      // RULE10 byte 1 mapping
      cs_n <= tb1[2:1];
      da <= tb1[5:3];
      scl_out <= tb1[6];
      // RULE13 data bus may float
      dd_oe_n <= ~tb1[7];
      // RULE11 bytes 2 to 4
      dd_out <= test_data_reg[31:16];
      gpio_out <= tb4[2:0];
      // RULE23 enable zero floats
      gpio_oe_n <= ~tb4[6:4];
      // RULE12 reserved bits unused
    end
    else
    begin
      low_power_indicator <= func_low_power_indicator;
      full_current_request_n <= func_full_current_request_n;
      drive_reset_n <= func_drive_reset_n;
      diow_n <= func_diow_n;
      dior_n <= func_dior_n;
      dmack_n <= func_dmack_n;
      disk_pullup_enable <= func_disk_pullup_enable;
      cs_n <= func_cs_n;
      da <= func_da;
      scl_out <= func_scl;
      dd_out <= func_dd_out;
      dd_oe_n <= func_dd_oe_n;
      gpio_out <= func_gpio_out;
      gpio_oe_n <= func_gpio_oe_n;
    end
  end
  // Checks
  sequence s_load(logic [15:0] v);
    exec && is_load && req_value == v;
  endsequence
  property p_reset_normal;
    @(posedge pclk) $rose(presetn) |-> !test_mode_reg;
  endproperty
  a_reset_normal: assert property (p_reset_normal) else $error("not normal after reset"); // RULE4
  property p_disable;
    @(posedge pclk) disable iff (!presetn) s_load(umpt_pkg::VAL_NORMAL) |=> !test_mode_reg ##1 !test_mode_reg;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not leave test mode"); // RULE4
  property p_enable;
    @(posedge pclk) disable iff (!presetn)
      s_load(umpt_pkg::VAL_TEST) ##0 (req_length == umpt_pkg::LEN_LOAD) |=> test_mode_reg;
  endproperty
  a_enable: assert property (p_enable) else $error("enable did not enter test mode"); // RULE5
  property p_long_stall;
    @(posedge pclk) disable iff (!presetn)
      s_load(umpt_pkg::VAL_TEST) ##0 (req_length > umpt_pkg::LEN_LOAD) |=> stall_reg && $stable(test_mode_reg);
  endproperty
  a_long_stall: assert property (p_long_stall) else $error("oversize load not stalled"); // RULE7
  property p_pin_follow;
    @(posedge pclk) disable iff (!presetn)
      test_mode_reg && $stable(test_data_reg) |=> diow_n == $past(tb0[4]) && da == $past(tb1[5:3]);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin not following test bit"); // RULE8
  property p_func_block;
    @(posedge pclk) disable iff (!presetn)
      test_mode_reg ##1 test_mode_reg |-> dd_out == $past(test_data_reg[31:16]);
  endproperty
  a_func_block: assert property (p_func_block) else $error("functional data reached pins"); // RULE2
  property p_gpio_float;
    @(posedge pclk) disable iff (!presetn) test_mode_reg |=> gpio_oe_n == ~$past(tb4[6:4]);
  endproperty
  a_gpio_float: assert property (p_gpio_float) else $error("gpio enable wrong"); // RULE23
  property p_read_stall;
    @(posedge pclk) disable iff (!presetn)
      exec && is_read && req_length > umpt_pkg::LEN_READ_MAX |=> stall_reg && $stable(snap_reg);
  endproperty
  a_read_stall: assert property (p_read_stall) else $error("long read not stalled"); // RULE15
  property p_read_keeps;
    @(posedge pclk) disable iff (!presetn)
      exec && is_read |=> $stable(test_mode_reg) && $stable(test_data_reg);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read altered test state"); // RULE18
  property p_snap_fixed;
    @(posedge pclk) disable iff (!presetn)
      exec && is_read && req_length == umpt_pkg::LEN_READ_MAX |=> snap_reg[9] && snap_reg[55:49] == 7'h7F
      && snap_reg[48] == $past(test_mode_reg);
  endproperty
  a_snap_fixed: assert property (p_snap_fixed) else $error("snapshot fixed bits wrong"); // RULE22

endmodule // umpt_pin_test

`default_nettype wire

// ==== verification/umpt_board_model.sv ====
// Purpose: Board-side model of the disk data bus and GPIO pads
// Assumes: External drivers on the board hold a level whenever the block floats a pad
// Notes: Pad level is resolved here and fed back to the block's pad inputs
`timescale 1ns/1ps
`default_nettype none
module umpt_board_model (
  input wire logic [15:0] dd_out, // Block data bus value
  input wire logic dd_oe_n, // Block data bus enable, low drives
  input wire logic [2:0] gpio_out, // Block GPIO values
  input wire logic [2:0] gpio_oe_n, // Block GPIO enables, low drives
  input wire logic [15:0] ext_dd, // Board driver level on the data bus
  input wire logic [2:0] ext_gpio, // Board driver levels on GPIO
  output logic [15:0] dd_in, // Resolved data bus pad level
  output logic [2:0] gpio_in // Resolved GPIO pad levels
);
  always_comb
  begin
    dd_in = dd_oe_n ? ext_dd : dd_out;
    for (int i = 0; i < 3; i++)
    begin
      gpio_in[i] = gpio_oe_n[i] ? ext_gpio[i] : gpio_out[i];
    end
  end
endmodule // umpt_board_model
`default_nettype wire

// ==== verification/usb_mfg_pin_test_control_tb_top.sv ====
// Purpose: Self-checking bench for the manufacturing pin test block
// Assumes: APB zero or more wait states; requests staged then executed
// Notes: Reserved readback bits are masked, the host must disregard them
`timescale 1ns/1ps
`default_nettype none
module usb_mfg_pin_test_control_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [35:0] func_v, pins;
  logic [8:0] misc;
  logic [15:0] ext_dd, dd_out, dd_in;
  logic [2:0] ext_gpio, gpio_out, gpio_oe_n, gpio_in, da;
  logic [1:0] cs_n;
  logic low_power_indicator, full_current_request_n, drive_reset_n, diow_n, dior_n, dmack_n;
  logic disk_pullup_enable, scl_out, dd_oe_n, test_mode;
  int num_errors, n_compared, cyc;
  localparam logic [55:0] PAT_A = 56'hFF_FF_1A_3C_A5_D5_FB;
  localparam logic [63:0] RSV_MASK = 64'hFFFF_FFFF_FFFB_F7FF;
  assign pins = {low_power_indicator, full_current_request_n, drive_reset_n, diow_n, dior_n, dmack_n,
    disk_pullup_enable, cs_n, da, scl_out, dd_out, dd_oe_n, gpio_out, gpio_oe_n};
  umpt_pin_test uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .func_low_power_indicator(func_v[35]), .func_full_current_request_n(func_v[34]),
    .func_drive_reset_n(func_v[33]), .func_diow_n(func_v[32]), .func_dior_n(func_v[31]),
    .func_dmack_n(func_v[30]), .func_disk_pullup_enable(func_v[29]), .func_cs_n(func_v[28:27]),
    .func_da(func_v[26:24]), .func_scl(func_v[23]), .func_dd_out(func_v[22:7]), .func_dd_oe_n(func_v[6]),
    .func_gpio_out(func_v[5:3]), .func_gpio_oe_n(func_v[2:0]), .low_power_indicator, .full_current_request_n,
    .drive_reset_n, .diow_n, .dior_n, .dmack_n, .disk_pullup_enable, .cs_n, .da, .scl_out, .dd_out, .dd_oe_n,
    .dd_in, .gpio_out, .gpio_oe_n, .gpio_in, .drive_power_valid(misc[0]), .bus_power_valid(misc[1]),
    .bus_powered_flag(misc[2]), .disk_ready_input(misc[3]), .system_interrupt_input(misc[4]), .iordy(misc[5]),
    .dmarq(misc[6]), .eject_request_n(misc[7]), .disk_interrupt_input(misc[8]), .test_mode);
  umpt_board_model board (.dd_out, .dd_oe_n, .gpio_out, .gpio_oe_n, .ext_dd, .ext_gpio, .dd_in, .gpio_in);
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic wrap_up();
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, far above the length of the sequence
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the bench timeout ends a wait for ready
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask
  task automatic exec(input logic [31:0] lo, input logic [31:0] hi, input logic st);
    logic [31:0] r;
    wr(umpt_pkg::OFS_SETUP_LO, lo);
    wr(umpt_pkg::OFS_SETUP_HI, hi);
    wr(umpt_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    rd(umpt_pkg::OFS_STATUS, r);
    check("stall", r[umpt_pkg::ST_STALL_BIT], st);
    check("done", r[umpt_pkg::ST_DONE_BIT], 1'b1);
    wr(umpt_pkg::OFS_STATUS, 32'h0000_0006);
  endtask
  function automatic logic [35:0] pins_of(input logic [55:0] d);
    return {d[0], d[2], d[3], d[4], d[5], d[6], d[7], d[10:9], d[13:11], d[14], d[31:16], ~d[15], d[34:32],
      ~d[38:36]};
  endfunction
  function automatic logic [63:0] snap_exp(input logic [35:0] p, input logic tm);
    logic [15:0] ddp;
    logic [2:0] gp;
    ddp = p[6] ? ext_dd : p[22:7];
    for (int i = 0; i < 3; i++)
      gp[i] = p[i] ? ext_gpio[i] : p[3 + i];
    return {8'h00, 7'h7F, tm, ~p[2:0], ~p[6], 1'b0, gp, ddp, p[26:24], p[28:27], 1'b0, p[29], p[30],
      p[31], p[32], p[33], p[34], 1'b0, p[35], 1'b1, misc[8], misc[7:0]};
  endfunction
  task automatic load(input logic [55:0] d, input logic [15:0] val);
    wr(umpt_pkg::OFS_DATA_LO, d[31:0]);
    wr(umpt_pkg::OFS_DATA_HI, {8'h00, d[55:32]});
    exec({val, umpt_pkg::REQ_LOAD, umpt_pkg::REQ_TYPE_OUT}, {umpt_pkg::LEN_LOAD, 16'h0000}, 1'b0);
  endtask
  task automatic snap(input logic [15:0] len, input logic [35:0] p, input logic tm);
    logic [31:0] l, h;
    logic [63:0] m;
    exec({umpt_pkg::VAL_NORMAL, umpt_pkg::REQ_READ, umpt_pkg::REQ_TYPE_IN}, {len, umpt_pkg::IDX_ZERO}, 1'b0);
    rd(umpt_pkg::OFS_SNAP_LO, l);
    rd(umpt_pkg::OFS_SNAP_HI, h);
    m = (len >= 8) ? RSV_MASK : RSV_MASK & ((64'h1 << (8 * len)) - 1);
    check("snapshot", {h, l} & m, snap_exp(p, tm) & m);
  endtask
  task automatic t_normal();
    check("reset pins", pins, func_v);
    check("reset mode", test_mode, 1'b0);
    func_v <= ~func_v;
    repeat (3) @(posedge pclk);
    check("functional pins", pins, func_v);
  endtask
  task automatic t_load();
    logic [31:0] r;
    load(PAT_A, umpt_pkg::VAL_TEST);
    check("mode on", test_mode, 1'b1);
    check("pattern A", pins, pins_of(PAT_A));
    func_v <= ~func_v;
    repeat (3) @(posedge pclk);
    check("functional blocked", pins, pins_of(PAT_A));
    rd(umpt_pkg::OFS_STATUS, r);
    check("status mode", r[umpt_pkg::ST_TEST_BIT], 1'b1);
  endtask
  task automatic t_refuse();
    logic [63:0] bad [9] = '{64'h0008_0000_0001_0540, 64'h0006_0000_0001_0540, 64'h0007_0000_0002_0540,
      64'h0007_0000_0001_0740, 64'h0007_0000_0001_0541, 64'h0009_0000_0000_06C0, 64'h0000_0000_0000_06C0,
      64'h0001_0000_0001_06C0, 64'h0001_0001_0000_06C0};
    wr(umpt_pkg::OFS_DATA_LO, ~PAT_A[31:0]);
    wr(umpt_pkg::OFS_DATA_HI, {8'h00, ~PAT_A[55:32]});
    foreach (bad[i])
    begin
      exec(bad[i][31:0], bad[i][63:32], 1'b1);
      check("refused keeps pins", pins, pins_of(PAT_A));
      check("refused keeps mode", test_mode, 1'b1);
    end
  endtask
  task automatic t_snapshot();
    load(~PAT_A, umpt_pkg::VAL_TEST);
    check("pattern B", pins, pins_of(~PAT_A));
    misc <= 9'h0D3;
    ext_dd <= 16'h93C6;
    ext_gpio <= 3'b010;
    repeat (4) @(posedge pclk);
    snap(16'h0008, pins_of(~PAT_A), 1'b1);
    snap(16'h0003, pins_of(~PAT_A), 1'b1);
    check("snapshot keeps mode", test_mode, 1'b1);
    check("snapshot keeps pins", pins, pins_of(~PAT_A));
  endtask
  task automatic t_unmapped();
    logic [31:0] r;
    logic e;
    apb(1'b0, 8'h20, 32'h0000_0000, r, e);
    check("unmapped error", e, 1'b1);
    check("unmapped data", r, 32'h0000_0000);
  endtask
  task automatic t_disable();
    exec({umpt_pkg::VAL_NORMAL, umpt_pkg::REQ_LOAD, umpt_pkg::REQ_TYPE_OUT}, 32'h0000_0000, 1'b0);
    check("mode off", test_mode, 1'b0);
    check("pins restored", pins, func_v);
    snap(16'h0008, func_v, 1'b0);
  endtask
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    func_v = 36'h9_A5C3_C3E6;
    misc = 9'h1A5;
    ext_dd = 16'h6C39;
    ext_gpio = 3'b101;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_normal();
    t_load();
    t_refuse();
    t_snapshot();
    t_unmapped();
    t_disable();
    wrap_up();
  end
endmodule // usb_mfg_pin_test_control_tb_top
`default_nettype wire
